// ### hdl/logic_state_trace_capture.sv
// Contract
// - address trace stores every address or, with cable source, only instruction fetches, per host bit.
// - capture only observes inputs; it never stalls or waits the target.
// - counted mode captures 1 to 256 samples; continuous mode also offered.
// - continuous mode wraps 256 entries until halt; holds last 256 qualified samples.
// - trace memory holds up to 256 samples of 20 bits each.
// - inputs are 20 data channels, 4 qualifiers, external clock, trigger.
// - samples marked unwanted by qualifiers are not written.
// - source is probe channels or emulator cable with control plus bus word.
// - four probe inputs may latch pulses until the next sample clock records them.
// - sample clock is internal 10 MHz or external clock up to 10 MHz.
// - external clock comes from cable when fitted, else from the probe lead.
// - event counter needs 1 to 65536 trigger occurrences before the trace.
// - programmable delay places trigger within the 256-entry trace.
`timescale 1ns/10ps
`include "trace_capture_defines.svh"
`default_nettype none
module logic_state_trace_capture #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 20
) (
  input  wire logic        core_clk_in,      // bus clock, 10 MHz
  input  wire logic        rst_n_in,         // sync reset, active low
  input  wire logic        wb_cyc_in,        // wishbone cycle
  input  wire logic        wb_stb_in,        // wishbone strobe
  input  wire logic        wb_we_in,         // wishbone write
  input  wire logic [7:0]  wb_adr_in,        // byte address
  input  wire logic [3:0]  wb_sel_in,        // byte lanes
  input  wire logic [31:0] wb_dat_in,        // write data
  output logic      [31:0] wb_dat_out,       // read data
  output logic             wb_ack_out,       // ack
  input  wire logic        ext_clk_in,       // probe lead sample clock, used when no cable fitted
  input  wire logic        cable_fitted_in,  // cable present strap
  input  wire logic [19:0] probe_data_in,    // probe channels
  input  wire logic [19:0] cable_data_in,    // cable control plus bus word
  input  wire logic        cable_fetch_in,   // cable: instruction fetch cycle
  input  wire logic        cable_ext_clk_in, // cable: sample clock
  input  wire logic [3:0]  qual_in,          // trace qualifiers
  input  wire logic        trigger_in,       // trace event trigger
  input  wire logic        halt_in,          // breakpoint halt from emulator
  output logic             done_out,         // capture complete
  output logic             busy_out          // capture armed
);
  // fixed 256 x 20 memory and datapath; other sizes are refused at elaboration
  if (DEPTH != 256 || WIDTH != 20)
  begin : g_size_check
    $error("trace capture supports only 256 x 20");
  end

  // core side registers
  logic [31:0] ctrl_q;
  logic [8:0]  count_q;
  logic [16:0] events_q;
  logic [8:0]  delay_q;
  logic [7:0]  rdptr_q;
  logic        arm_tgl_q;
  logic        wb_ack_q;
  logic [31:0] wb_dat_q;
  logic        done_q;
  logic        busy_q;
  logic        wr_hit;
  logic        rd_hit;
  assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_q; // write lands on the acknowledged edge
  assign rd_hit = wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_q;

  // sample clock mux: one link domain clock, ext from cable when fitted
  logic samp_clk;
  logic ext_sel_clk;
  assign ext_sel_clk = cable_fitted_in ? cable_ext_clk_in : ext_clk_in;
  // internal clock is core clock since both are 10 MHz; glitchy switch accepted, host switches while idle
  assign samp_clk = ctrl_q[`TC_CTRL_EXTCLK] ? ext_sel_clk : core_clk_in;

  // link side state
  trace_capture_pkg::cap_state_t st_q;
  logic [7:0]  wptr_q;
  logic [8:0]  left_q;
  logic [16:0] evcnt_q;
  logic [8:0]  stored_q;
  logic        arm_s1_q, arm_s2_q, arm_s3_q;
  logic        lrst_s1_q, lrst_s2_q;
  logic        trig_s1_q, trig_s2_q, trig_s3_q;
  logic        halt_s1_q, halt_s2_q;
  logic [19:0] pdat_s1_q, pdat_s2_q;
  logic [19:0] cdat_s1_q, cdat_s2_q;
  logic        fetch_s1_q, fetch_s2_q;
  logic [3:0]  qual_s1_q, qual_s2_q;
  logic        done_tgl_q;
  logic        busy_l_q;
  logic [3:0]  glitch_q;
  trace_capture_pkg::sample_t mem [0:255];

  // reset carried into link domain
  always_ff @(posedge samp_clk)
  begin
    lrst_s1_q <= rst_n_in;
    lrst_s2_q <= lrst_s1_q;
  end

  // two-stage sync of data, qualifier, trigger pins onto sample clock; capture only listens
  always_ff @(posedge samp_clk)
  begin
    arm_s1_q   <= arm_tgl_q;
    arm_s2_q   <= arm_s1_q;
    trig_s1_q  <= trigger_in;
    trig_s2_q  <= trig_s1_q;
    halt_s1_q  <= halt_in;
    halt_s2_q  <= halt_s1_q;
    pdat_s1_q  <= probe_data_in;
    pdat_s2_q  <= pdat_s1_q;
    cdat_s1_q  <= cable_data_in;
    cdat_s2_q  <= cdat_s1_q;
    fetch_s1_q <= cable_fetch_in;
    fetch_s2_q <= fetch_s1_q;
    qual_s1_q  <= qual_in;
    qual_s2_q  <= qual_s1_q;
  end

  // pulse latches: sticky high until recorded; pulses under one clock caught only if synchroniser sees them
  logic [3:0] glitch_set;
  assign glitch_set = pdat_s2_q[3:0] & ctrl_q[`TC_CTRL_LATCH +: 4];

  // selected sample and qualification
  logic [19:0] sample;
  logic        qual_ok;
  logic        fetch_ok;
  logic        trig_edge;
  logic        take;
  always_comb
  begin
    sample = ctrl_q[`TC_CTRL_SRC] ? cdat_s2_q : pdat_s2_q;
    if (!ctrl_q[`TC_CTRL_SRC])
      sample[3:0] = (pdat_s2_q[3:0] & ~ctrl_q[`TC_CTRL_LATCH +: 4])
                  | ((glitch_q | glitch_set) & ctrl_q[`TC_CTRL_LATCH +: 4]);
  end
  // qualifier enabled lines must match polarity
  assign qual_ok  = &(~ctrl_q[`TC_CTRL_QUALEN +: 4] | ~(qual_s2_q ^ ctrl_q[`TC_CTRL_QUALPOL +: 4]));
  assign fetch_ok = !(ctrl_q[`TC_CTRL_SRC] && ctrl_q[`TC_CTRL_FETCH]) || fetch_s2_q;
  assign trig_edge = trig_s2_q && !trig_s3_q;
  assign take = qual_ok && fetch_ok && (st_q == trace_capture_pkg::ST_ARMED || st_q == trace_capture_pkg::ST_POST);

  // latch clear on record
  always_ff @(posedge samp_clk)
  begin
    if (!lrst_s2_q)
      glitch_q <= 4'h0;
    else if (take)
      glitch_q <= 4'h0;
    else
      glitch_q <= glitch_q | glitch_set;
  end

  // trace memory write, qualified samples only
  always_ff @(posedge samp_clk)
  begin
    if (take)
      mem[wptr_q] <= sample;
  end

  // capture engine
  always_ff @(posedge samp_clk)
  begin
    if (!lrst_s2_q)
    begin
      st_q       <= trace_capture_pkg::ST_IDLE;
      wptr_q     <= 8'h00;
      left_q     <= 9'h000;
      evcnt_q    <= 17'h0_0000;
      stored_q   <= 9'h000;
      arm_s3_q   <= 1'b0;
      trig_s3_q  <= 1'b0;
      done_tgl_q <= 1'b0;
      busy_l_q   <= 1'b0;
    end
    else
    begin
      arm_s3_q  <= arm_s2_q;
      trig_s3_q <= trig_s2_q;
      if (arm_s2_q != arm_s3_q)
      begin
        st_q     <= trace_capture_pkg::ST_ARMED;
        wptr_q   <= 8'h00;
        stored_q <= 9'h000;
        evcnt_q  <= 17'h0_0000;
        busy_l_q <= 1'b1;
        // counted mode without trigger: count is length
        // a delay at or past count loads zero instead of wrapping; ST_POST then ends on its first cycle, storing that cycle's sample only if it qualifies
        left_q   <= !ctrl_q[`TC_CTRL_TRIGEN] ? count_q : ((delay_q >= count_q) ? 9'h000 : (count_q - delay_q));
      end
      else
      begin
        if (take)
        begin
          wptr_q <= wptr_q + 8'h01; // wraps
          if (stored_q != 9'h100)
            stored_q <= stored_q + 9'h001;
        end
        unique case (st_q)
          trace_capture_pkg::ST_IDLE:
          begin
          end
          trace_capture_pkg::ST_ARMED:
          begin
            if (ctrl_q[`TC_CTRL_TRIGEN])
            begin
              if (trig_edge)
              begin
                // event counter
                if (evcnt_q + 17'h0_0001 >= events_q)
                  st_q <= trace_capture_pkg::ST_POST;
                evcnt_q <= evcnt_q + 17'h0_0001;
              end
            end
            else if (ctrl_q[`TC_CTRL_CONT])
            begin
              if (ctrl_q[`TC_CTRL_HALT] && halt_s2_q)
                st_q <= trace_capture_pkg::ST_DONE;
            end
            else if (take)
            begin
              if (left_q == 9'h001)
                st_q <= trace_capture_pkg::ST_DONE;
              left_q <= left_q - 9'h001;
            end
          end
          trace_capture_pkg::ST_POST:
          begin
            // post-trigger samples, rest of buffer holds pre-trigger
            if (left_q == 9'h000)
              st_q <= trace_capture_pkg::ST_DONE;
            else if (take)
            begin
              if (left_q == 9'h001)
                st_q <= trace_capture_pkg::ST_DONE;
              left_q <= left_q - 9'h001;
            end
          end
          trace_capture_pkg::ST_DONE:
          begin
          end
        endcase
        if (st_q != trace_capture_pkg::ST_DONE && st_q != trace_capture_pkg::ST_IDLE &&
            ((st_q == trace_capture_pkg::ST_ARMED && !ctrl_q[`TC_CTRL_TRIGEN] && !ctrl_q[`TC_CTRL_CONT] &&
              take && left_q == 9'h001) ||
             (st_q == trace_capture_pkg::ST_ARMED && ctrl_q[`TC_CTRL_CONT] && !ctrl_q[`TC_CTRL_TRIGEN] &&
              ctrl_q[`TC_CTRL_HALT] && halt_s2_q) ||
             (st_q == trace_capture_pkg::ST_POST && (left_q == 9'h000 || (take && left_q == 9'h001)))))
        begin
          done_tgl_q <= !done_tgl_q;
          busy_l_q   <= 1'b0;
        end
      end
    end
  end

  // back to core: toggle and level through two flops
  logic dn_s1_q, dn_s2_q, dn_s3_q, bz_s1_q, bz_s2_q;
  always_ff @(posedge core_clk_in)
  begin
    dn_s1_q <= done_tgl_q;
    dn_s2_q <= dn_s1_q;
    bz_s1_q <= busy_l_q;
    bz_s2_q <= bz_s1_q;
  end

  // host registers; halt stops writes so stale rdata only read when not busy
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_q    <= `TC_CTRL_RESET;
      count_q   <= `TC_COUNT_RESET;
      events_q  <= `TC_EVENTS_RESET;
      delay_q   <= `TC_DELAY_RESET;
      rdptr_q   <= 8'h00;
      arm_tgl_q <= 1'b0;
      dn_s3_q   <= 1'b0;
      done_q    <= 1'b0;
      busy_q    <= 1'b0;
    end
    else
    begin
      dn_s3_q <= dn_s2_q;
      busy_q  <= bz_s2_q;
      if (wr_hit && wb_adr_in == `TC_REG_CTRL && wb_sel_in == 4'hF)
      begin
        ctrl_q <= {wb_dat_in[31:1], 1'b0};
        if (wb_dat_in[`TC_CTRL_ARM])
          arm_tgl_q <= !arm_tgl_q;
      end
      if (wr_hit && wb_adr_in == `TC_REG_COUNT && wb_dat_in[8:0] != 9'h000 && wb_dat_in[8:0] <= 9'h100)
        count_q <= wb_dat_in[8:0];
      if (wr_hit && wb_adr_in == `TC_REG_EVENTS && wb_dat_in[16:0] != 17'h0_0000 && wb_dat_in[16:0] <= 17'h1_0000)
        events_q <= wb_dat_in[16:0];
      if (wr_hit && wb_adr_in == `TC_REG_DELAY && wb_dat_in[8:0] <= 9'h100)
        delay_q <= wb_dat_in[8:0];
      if (wr_hit && wb_adr_in == `TC_REG_RDPTR)
        rdptr_q <= wb_dat_in[7:0];
      else if (rd_hit && wb_adr_in == `TC_REG_RDDATA)
        rdptr_q <= rdptr_q + 8'h01;
      // set beats clear
      if (dn_s2_q != dn_s3_q)
        done_q <= 1'b1;
      else if ((rd_hit && wb_adr_in == `TC_REG_RDDATA) ||
               (wr_hit && wb_adr_in == `TC_REG_CTRL && wb_dat_in[`TC_CTRL_ARM]))
        done_q <= 1'b0;
    end
  end

  // wishbone answer, one cycle after request
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_q <= wb_cyc_in && wb_stb_in && !wb_ack_q;
      wb_dat_q <= 32'h0000_0000;
      if (rd_hit)
      begin
        case (wb_adr_in)
          `TC_REG_CTRL:   wb_dat_q <= ctrl_q;
          `TC_REG_COUNT:  wb_dat_q <= {23'h00_0000, count_q};
          `TC_REG_EVENTS: wb_dat_q <= {15'h0000, events_q};
          `TC_REG_DELAY:  wb_dat_q <= {23'h00_0000, delay_q};
          `TC_REG_STATUS: wb_dat_q <= {30'h0000_0000, busy_q, done_q};
          `TC_REG_RDPTR:  wb_dat_q <= {24'h00_0000, rdptr_q};
          `TC_REG_RDDATA: wb_dat_q <= {12'h000, mem[rdptr_q]};
          default:        wb_dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_out = wb_ack_q;
  assign wb_dat_out = wb_dat_q;
  assign done_out   = done_q;
  assign busy_out   = busy_q;
endmodule
`default_nettype wire

// ### hdl/trace_capture_defines.svh
`ifndef TRACE_CAPTURE_DEFINES_SVH
`define TRACE_CAPTURE_DEFINES_SVH
// register byte addresses
`define TC_REG_CTRL      8'h00
`define TC_REG_COUNT     8'h04
`define TC_REG_EVENTS    8'h08
`define TC_REG_DELAY     8'h0C
`define TC_REG_STATUS    8'h10
`define TC_REG_RDPTR     8'h14
`define TC_REG_RDDATA    8'h18
// control field positions
`define TC_CTRL_ARM      0
`define TC_CTRL_CONT     1
`define TC_CTRL_FETCH    2
`define TC_CTRL_SRC      3
`define TC_CTRL_EXTCLK   4
`define TC_CTRL_TRIGEN   5
`define TC_CTRL_HALT     6
`define TC_CTRL_LATCH    8
`define TC_CTRL_QUALEN   12
`define TC_CTRL_QUALPOL  16
// reset values
`define TC_CTRL_RESET    32'h0000_0000
`define TC_COUNT_RESET   9'h100
`define TC_EVENTS_RESET  17'h0_0001
`define TC_DELAY_RESET   9'h080
// timing
`define TC_INT_CLK_HZ    10000000
`define TC_CORE_CLK_HZ   10000000
`define TC_INT_DIV       (`TC_CORE_CLK_HZ / `TC_INT_CLK_HZ)
`endif

// ### hdl/trace_capture_pkg.sv
`default_nettype none
package trace_capture_pkg;
  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_POST  = 4'b0100,
    ST_DONE  = 4'b1000
  } cap_state_t;
  typedef logic [19:0] sample_t;
endpackage
`default_nettype wire

// ### verif/trace_capture_props.sv
`timescale 1ns/10ps
`default_nettype none
module trace_capture_props (
  input wire logic        core_clk_in, // core clock
  input wire logic        rst_n_in,    // sync reset
  input wire logic        wb_cyc_in,   // cycle
  input wire logic        wb_stb_in,   // strobe
  input wire logic        wb_we_in,    // write
  input wire logic [7:0]  wb_adr_in,   // address
  input wire logic [31:0] wb_dat_in,   // write data
  input wire logic [31:0] wb_dat_out,  // read data
  input wire logic        wb_ack_out,  // ack
  input wire logic        done_out,    // capture done
  input wire logic        busy_out     // capture running
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // a request is live while cycle and strobe are both high
  wire logic req = wb_cyc_in && wb_stb_in;
  // bus handshake
  chk_ack_next: assert property (req && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
  chk_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in >= 8'h1C
    |-> wb_dat_out == 32'h0000_0000) else $error("unmapped read not zero");
  // reset must quiet ack, done and busy, so it is not disabled by reset itself
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_n_in
    |=> !wb_ack_out && !done_out && !busy_out) else $error("outputs live in reset");
  // done may only fall after host traffic
  chk_done_holds: assert property (done_out && !req && !$past(req) && !$past(req, 2) |=> done_out)
    else $error("done dropped");
  chk_done_idle: assert property ($rose(done_out) |-> !busy_out) else $error("done while busy");
  chk_arm_starts: assert property (req && !wb_ack_out && wb_we_in && wb_adr_in == 8'h00 && wb_dat_in[0]
    |-> ##[2:12] (busy_out || done_out)) else $error("arm ignored");
  cover property ($rose(done_out));
  cover property ($rose(busy_out));
  cover property (wb_ack_out && wb_adr_in >= 8'h1C);
endmodule
`default_nettype wire

// ### verif/trace_target_model.sv
`timescale 1ns/10ps
`default_nettype none
module trace_target_model (
  output logic        lclk_out,  // target sample clock
  output logic [19:0] data_out,  // bus word, counts up
  output logic [3:0]  qual_out,  // qualifiers from low data bits
  output logic        fetch_out  // fetch marker on odd words
);
  // free clock from the target, offset so it never lines up with the core
  initial
  begin
    lclk_out = 1'b0;
    data_out = 20'h0_0000;
    #7;
    forever #16 lclk_out = ~lclk_out;
  end
  // target runs on and never waits for the tracer
  always @(posedge lclk_out)
    data_out <= data_out + 20'h0_0001;
  assign qual_out = data_out[3:0];
  assign fetch_out = data_out[0];
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`include "trace_capture_defines.svh"
`default_nettype none
module tb_top;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wb_cyc_in = 1'b0;
  logic        wb_stb_in = 1'b0;
  logic        wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0000_0000;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        done_out;
  logic        busy_out;
  logic        lclk;
  logic        fit = 1'b0;
  logic        trig = 1'b0;
  logic        halt = 1'b0;
  logic [19:0] tdat;
  logic [3:0]  tq;
  logic        tfetch;
  logic [31:0] r;
  logic [19:0] m [$];
  int          num_errors = 0;
  int          total_checks = 0;
  int          seed = 32'h0f78_2eab;
  int          n;
  int          tv;
  int          nb;
  int          regs [8];
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  logic [7:0]  wa [8] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h04, 8'h08, 8'h0C};
  int          wd [8] = '{0, 257, 0, 257, 5, 1, 65536, 256};
  logic [31:0] ctl [4] = '{32'h0000_0011, 32'h0000_001D, 32'h0000_1011, 32'h0000_0001};
  int          st [4] = '{1, 2, 2, 3};
  // core clock, 100 ns period
  always #50 core_clk_in = ~core_clk_in;
  trace_target_model i_trace_target_model (.lclk_out(lclk), .data_out(tdat), .qual_out(tq), .fetch_out(tfetch));
  logic_state_trace_capture i_logic_state_trace_capture (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .ext_clk_in(lclk),
    .cable_fitted_in(fit), .probe_data_in(tdat), .cable_data_in(tdat), .cable_fetch_in(tfetch),
    .cable_ext_clk_in(lclk), .qual_in(tq), .trigger_in(trig), .halt_in(halt), .done_out(done_out),
    .busy_out(busy_out));
  // verdict and exit in one place
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail(input string s);
    num_errors++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    total_checks++;
    if (g !== e)
      fail($sformatf("%s got %h exp %h", s, g, e));
  endtask
  // one classic cycle; held until ack is seen, then released for a cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_sel_in <= 4'hF;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do
    begin
      @(posedge core_clk_in);
      k++;
    end
    while (wb_ack_out !== 1'b1 && k < 20);
    r = wb_dat_out;
    if (k >= 20)
    begin
      fail("ack timeout");
      end_of_test();
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(r, e, "read");
  endtask
  // model keeps only writes the block is meant to accept
  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, 32'(d));
    if ((a == 8'h04 && d >= 1 && d <= 256) || (a == 8'h08 && d >= 1 && d <= 65536) || (a == 8'h0C && d <= 256))
      regs[a[4:2]] = d;
  endtask
  task automatic wait_lv(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 5000)
    begin
      @(posedge core_clk_in);
      k++;
    end
    if (k >= 5000)
    begin
      fail("wait timeout");
      end_of_test();
    end
  endtask
  // pull n words out of the trace and count breaks in the expected step
  task automatic grab(input int cnt, input int stp, input int lim);
    int b;
    b = 0;
    m.delete();
    wr(8'h14, 0);
    repeat (cnt)
    begin
      bus(1'b0, 8'h18, 32'h0000_0000);
      m.push_back(r[19:0]);
    end
    for (int k = 1; k < m.size(); k++)
      b += int'(m[k] !== 20'(m[k-1] + stp));
    chk(32'(b <= lim), 32'h0000_0001, "trace order");
  endtask
  task automatic pulse();
    // word on the target bus as the trigger rises; the trigger sample holds it
    tv = tdat;
    trig <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    trig <= 1'b0;
    repeat (3) @(posedge core_clk_in);
  endtask
  // main sequence
  initial
  begin
    regs = '{0, `TC_COUNT_RESET, `TC_EVENTS_RESET, `TC_DELAY_RESET, 0, 0, 0, 0};
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    foreach (ra[i]) rd(ra[i], regs[ra[i][4:2]]);
    foreach (wa[i]) wr(wa[i], wd[i]);
    foreach (ra[i]) rd(ra[i], regs[ra[i][4:2]]);
    $display("test 1 registers done");
    foreach (ctl[i])
    begin
      n = (i == 1) ? 256 : 1 + ({$random(seed)} % 16);
      fit <= ctl[i][3];
      wr(8'h04, n);
      wr(8'h00, ctl[i]);
      wait_lv(done_out, 1'b1);
      rd(8'h10, 32'h0000_0001);
      // internal clock takes the 32 ns target word every 100 ns: steps of 3, now and then 4
      grab(n, st[i], (i == 3) ? 3 : 0);
      rd(8'h10, 32'h0000_0000);
      $display("test 2 capture %0d done", i);
    end
    fit <= 1'b0;
    // qualifier 1 keeps words with bit1 low; latch on bit0 carries the skipped odd word
    wr(8'h04, 16);
    wr(8'h00, 32'h0000_2111);
    wait_lv(done_out, 1'b1);
    grab(16, 4, 8);
    nb = 0;
    foreach (m[k]) nb += int'(m[k][1:0] !== 2'b01);
    chk(32'(nb), 32'h0000_0000, "pulse latch");
    $display("test 2 latch done");
    wr(8'h08, 3);
    wr(8'h0C, 2);
    wr(8'h04, 8);
    wr(8'h00, 32'h0000_0031);
    repeat (2) pulse();
    repeat (30) @(posedge core_clk_in);
    rd(8'h10, 32'h0000_0002);
    pulse();
    wait_lv(done_out, 1'b1);
    grab(8, 1, 1);
    // newest word must be the trigger word plus count minus delay post samples
    wr(8'h14, 0);
    n = 0;
    repeat (256)
    begin
      bus(1'b0, 8'h18, 32'h0000_0000);
      if (int'(r[19:0]) > n)
        n = int'(r[19:0]);
    end
    chk(32'(n), 32'(tv + 8 - 2), "trigger place");
    $display("test 3 trigger done");
    wr(8'h00, 32'h0000_0053);
    repeat (400) @(posedge core_clk_in);
    rd(8'h10, 32'h0000_0002);
    halt <= 1'b1;
    wait_lv(busy_out, 1'b0);
    grab(256, 1, 1);
    halt <= 1'b0;
    $display("test 4 continuous done");
    end_of_test();
  end
endmodule
bind logic_state_trace_capture trace_capture_props i_trace_capture_props (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .done_out(done_out), .busy_out(busy_out));
`default_nettype wire
